// *** core/sci_status_error_flags.sv ***
// Status flags, error detection and ninth-bit storage of an asynchronous serial interface.
// Assumes the receive and transmit shifters sit outside and report their events on the same clock.
// Operation
// - Nine-bit mode: received ninth bit stored with the data transfer.
// - Eight-bit mode: received ninth bit mirrors data bit seven.
// - Nine-bit mode: transmit ninth bit loaded with buffer into shifter.
// - Both ninth bits keep their value across reset.
// - Four error enables gate the error flag interrupts; reset clears noise, framing, parity.
// - Transmit empty sets on handoff, clears by status read then data write.
// - Transmit complete sets when empty and nothing is sent; reset sets.
// - Transmit complete clears as soon as anything is queued.
// - Receive full sets on transfer, clears by status read then data read.
// - Idle sets after ten or eleven ones, clears by status then data read.
// - Idle detection arms only after a valid character sets receive full.
// - Overrun sets when character completes with receive full set; new data dropped.
// - Data read clears only flags seen set at the preceding status read.
// - Noise flag sets on noise, clears by status then data read.
// - Framing flag sets on zero stop bit, clears by status then data read.
// - Parity flag sets on mismatch, clears by status then data read.
// - Break sets break, framing and receive full; framing and receive full raise their enabled interrupts; clears ninth bit in nine-bit mode.
// - Break clears by second status read then data read; rearms after ones.
// - Receive in progress sets on first sample zero; clears on character done, false start or idle.
// - Character length select decides whether ninth bits carry data.
// - Module disable forces transmit empty and complete, blocks transmit interrupts.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
module sci_status_error_flags (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic [7:0]               paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     rx_pin,
    input  wire logic                     bit_tick,
    input  wire sci_flags_pkg::rx_event_t rx_ev,
    input  wire sci_flags_pkg::tx_event_t tx_ev,
    output logic [8:0]                    tx_load_data,
    output logic                          tx_load,
    output logic                          tx_irq,
    output logic                          rx_irq,
    output logic                          err_irq
);

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic [7:0]  aux;
        logic        ovie;
        logic        nsie;
        logic        frie;
        logic        paie;
        logic        txe;
        logic        txc;
        logic        rxf;
        logic        idle;
        logic        ovr;
        logic        noise;
        logic        frame;
        logic        par;
        logic        brk;
        logic        brk_rearm;
        logic        rip;
        logic        idle_armed;
        logic [7:0]  s1_seen;
        logic        s2_brk_seen;
        logic [8:0]  tx_load_data;
        logic        tx_load;
        logic        tx_irq;
        logic        rx_irq;
        logic        err_irq;
    } flags_state_t;

    // Ninth bits and the data buffers live outside the reset struct because reset leaves them alone.
    flags_state_t state;
    flags_state_t next_state;
    logic [7:0]   rx_buf;
    logic [7:0]   tx_buf;
    logic         rx9;
    logic         tx9;
    logic         rx_sync1;
    logic         rx_sync2;
    logic         idle_hit;

    // -----------------------------------------------------------------------
    // Pin synchroniser
    // -----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        rx_sync1 <= rx_pin;
        rx_sync2 <= rx_sync1;
    end

    sci_idle_detect u_idle (
        .clock    (clock),
        .rst      (rst),
        .bit_tick (bit_tick),
        .rx_level (rx_sync2),
        .nine_bit (state.aux[sci_flags_pkg::AX_NINE]),
        .armed    (state.idle_armed && state.aux[sci_flags_pkg::AX_RXEN]),
        .idle_hit (idle_hit)
    );

    // -----------------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------------
    logic access;
    logic wr;
    logic rd;
    logic en;
    logic nine;
    logic rx_accept;

    assign access    = psel && penable && !state.ready;
    assign wr        = access && pwrite;
    assign rd        = access && !pwrite;
    assign en        = state.aux[sci_flags_pkg::AX_EN];
    assign nine      = state.aux[sci_flags_pkg::AX_NINE];
    assign rx_accept = rx_ev.done && !state.rxf;

    always_comb begin
        logic data_rd;
        logic data_wr;
        data_rd    = rd && paddr == sci_flags_pkg::ADDR_DATA;
        data_wr    = wr && paddr == sci_flags_pkg::ADDR_DATA;
        next_state = state;
        next_state.ready  = access;
        next_state.slverr = 1'b0;
        next_state.rdata  = sci_flags_pkg::READ_ZERO;
        next_state.tx_load = 1'b0;

        // Clears first so that a set in the same cycle wins.
        if (data_rd) begin
            if (state.s1_seen[sci_flags_pkg::S1_RXF])   next_state.rxf   = 1'b0;
            if (state.s1_seen[sci_flags_pkg::S1_IDLE])  next_state.idle  = 1'b0;
            if (state.s1_seen[sci_flags_pkg::S1_OVR])   next_state.ovr   = 1'b0;
            if (state.s1_seen[sci_flags_pkg::S1_NOISE]) next_state.noise = 1'b0;
            if (state.s1_seen[sci_flags_pkg::S1_FRAME]) next_state.frame = 1'b0;
            if (state.s1_seen[sci_flags_pkg::S1_PAR])   next_state.par   = 1'b0;
            if (state.s2_brk_seen) begin
                next_state.brk       = 1'b0;
                next_state.brk_rearm = 1'b0;
            end
            if (state.s1_seen[sci_flags_pkg::S1_IDLE]) next_state.idle_armed = 1'b0;
            next_state.s1_seen     = '0;
            next_state.s2_brk_seen = 1'b0;
        end
        if (data_wr && state.s1_seen[sci_flags_pkg::S1_TXE]) begin
            next_state.txe     = 1'b0;
            next_state.s1_seen = '0;
        end

        // Register reads and writes.
        if (rd) begin
            unique case (paddr)
                sci_flags_pkg::ADDR_CTRL3: begin
                    next_state.rdata[sci_flags_pkg::C3_RX9]  = rx9;
                    next_state.rdata[sci_flags_pkg::C3_TX9]  = tx9;
                    next_state.rdata[sci_flags_pkg::C3_OVIE] = state.ovie;
                    next_state.rdata[sci_flags_pkg::C3_NSIE] = state.nsie;
                    next_state.rdata[sci_flags_pkg::C3_FRIE] = state.frie;
                    next_state.rdata[sci_flags_pkg::C3_PAIE] = state.paie;
                end
                sci_flags_pkg::ADDR_STATUS1: begin
                    next_state.rdata[7:0] = {state.txe, state.txc, state.rxf, state.idle,
                                             state.ovr, state.noise, state.frame, state.par};
                    next_state.s1_seen    = {state.txe, state.txc, state.rxf, state.idle,
                                             state.ovr, state.noise, state.frame, state.par};
                end
                sci_flags_pkg::ADDR_STATUS2: begin
                    next_state.rdata[sci_flags_pkg::S2_BRK] = state.brk;
                    next_state.rdata[sci_flags_pkg::S2_RIP] = state.rip;
                    next_state.s2_brk_seen = state.brk;
                end
                sci_flags_pkg::ADDR_DATA: begin
                    next_state.rdata[7:0] = rx_buf;
                end
                sci_flags_pkg::ADDR_CTRL_AUX: begin
                    next_state.rdata[7:0] = state.aux;
                end
                default: begin
                    next_state.slverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            unique case (paddr)
                sci_flags_pkg::ADDR_CTRL3: begin
                    next_state.ovie = pwdata[sci_flags_pkg::C3_OVIE];
                    next_state.nsie = pwdata[sci_flags_pkg::C3_NSIE];
                    next_state.frie = pwdata[sci_flags_pkg::C3_FRIE];
                    next_state.paie = pwdata[sci_flags_pkg::C3_PAIE];
                end
                sci_flags_pkg::ADDR_CTRL_AUX: begin
                    next_state.aux = pwdata[7:0];
                end
                sci_flags_pkg::ADDR_STATUS1, sci_flags_pkg::ADDR_STATUS2, sci_flags_pkg::ADDR_DATA: begin
                end
                default: begin
                    next_state.slverr = 1'b1;
                end
            endcase
        end

        // Transmit side.
        if (tx_ev.load_req && !state.txe) begin
            next_state.tx_load      = 1'b1;
            next_state.tx_load_data = {nine ? tx9 : 1'b0, tx_buf};
            next_state.txe          = 1'b1;
        end
        if (tx_ev.queued) begin
            next_state.txc = 1'b0;
        end else if (next_state.txe && !tx_ev.busy) begin
            next_state.txc = 1'b1;
        end
        if (!en) begin
            next_state.txe = 1'b1;
            next_state.txc = 1'b1;
        end

        // Receive side.
        if (rx_ev.done) begin
            if (state.rxf) begin
                next_state.ovr = 1'b1;
            end else begin
                next_state.rxf        = 1'b1;
                next_state.idle_armed = 1'b1;
                if (rx_ev.noise)      next_state.noise = 1'b1;
                if (rx_ev.frame_err)  next_state.frame = 1'b1;
                if (rx_ev.parity_err) next_state.par   = 1'b1;
            end
            next_state.rip = 1'b0;
        end
        if (rx_ev.brk && state.brk_rearm) begin
            next_state.brk   = 1'b1;
            next_state.frame = 1'b1;
            next_state.rxf   = 1'b1;
        end
        if (!state.brk && rx_sync2) begin
            next_state.brk_rearm = 1'b1;
        end
        if (rx_ev.start_seen) next_state.rip = 1'b1;
        if (rx_ev.false_start || idle_hit) next_state.rip = 1'b0;
        if (idle_hit) next_state.idle = 1'b1;

        // Interrupt requests.
        next_state.tx_irq  = en && ((next_state.txe && state.aux[sci_flags_pkg::AX_TXEIE]) ||
                                    (next_state.txc && state.aux[sci_flags_pkg::AX_TXCIE]));
        next_state.rx_irq  = (next_state.rxf && state.aux[sci_flags_pkg::AX_RXFIE]) ||
                             (next_state.idle && state.aux[sci_flags_pkg::AX_IDLIE]);
        next_state.err_irq = (next_state.ovr && next_state.ovie) || (next_state.noise && next_state.nsie) ||
                             (next_state.frame && next_state.frie) || (next_state.par && next_state.paie);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state       <= '0;
            state.aux   <= sci_flags_pkg::AUX_RESET;
            state.txe   <= 1'b1;
            state.txc   <= 1'b1;
            state.brk_rearm <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------------------
    // Data buffers and ninth bits, untouched by reset
    // -----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rx_accept) begin
            rx_buf <= rx_ev.data[7:0];
            rx9    <= nine ? rx_ev.data[8] : rx_ev.data[7];
        end else if (rx_ev.brk && nine) begin
            rx9 <= 1'b0;
        end
        if (wr && paddr == sci_flags_pkg::ADDR_DATA) begin
            tx_buf <= pwdata[7:0];
        end
        if (wr && paddr == sci_flags_pkg::ADDR_CTRL3) begin
            tx9 <= pwdata[sci_flags_pkg::C3_TX9];
        end
    end

    assign prdata       = state.rdata;
    assign pready       = state.ready;
    assign pslverr      = state.slverr;
    assign tx_load_data = state.tx_load_data;
    assign tx_load      = state.tx_load;
    assign tx_irq       = state.tx_irq;
    assign rx_irq       = state.rx_irq;
    assign err_irq      = state.err_irq;

endmodule

// *** core/sci_flags_pkg.sv ***
// Package for the serial status and error flag block: register map, field positions and carriers.
// Assumes a single 125 MHz clock domain and an APB register bus with 32-bit data.
package sci_flags_pkg;

    // -----------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -----------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL3    = 8'h00;
    localparam logic [7:0] ADDR_STATUS1  = 8'h04;
    localparam logic [7:0] ADDR_STATUS2  = 8'h08;
    localparam logic [7:0] ADDR_DATA     = 8'h0C;
    localparam logic [7:0] ADDR_CTRL_AUX = 8'h10;

    // -----------------------------------------------------------------------
    // Control register three fields
    // -----------------------------------------------------------------------
    localparam int C3_RX9   = 7;
    localparam int C3_TX9   = 6;
    localparam int C3_OVIE  = 3;
    localparam int C3_NSIE  = 2;
    localparam int C3_FRIE  = 1;
    localparam int C3_PAIE  = 0;

    // -----------------------------------------------------------------------
    // Status register one fields
    // -----------------------------------------------------------------------
    localparam int S1_TXE   = 7;
    localparam int S1_TXC   = 6;
    localparam int S1_RXF   = 5;
    localparam int S1_IDLE  = 4;
    localparam int S1_OVR   = 3;
    localparam int S1_NOISE = 2;
    localparam int S1_FRAME = 1;
    localparam int S1_PAR   = 0;

    // -----------------------------------------------------------------------
    // Status register two fields
    // -----------------------------------------------------------------------
    localparam int S2_BRK   = 1;
    localparam int S2_RIP   = 0;

    // -----------------------------------------------------------------------
    // Auxiliary control fields
    // -----------------------------------------------------------------------
    localparam int AX_EN    = 0;
    localparam int AX_RXEN  = 1;
    localparam int AX_NINE  = 2;
    localparam int AX_TXEIE = 3;
    localparam int AX_TXCIE = 4;
    localparam int AX_RXFIE = 5;
    localparam int AX_IDLIE = 6;

    localparam logic [7:0]  AUX_RESET  = 8'h00;
    localparam logic [31:0] READ_ZERO  = 32'h0000_0000;
    localparam logic [3:0]  IDLE_SHORT = 4'h9;
    localparam logic [3:0]  IDLE_LONG  = 4'hA;

    // -----------------------------------------------------------------------
    // Receiver event bundle delivered by the receive shifter
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic       done;
        logic [8:0] data;
        logic       noise;
        logic       frame_err;
        logic       parity_err;
        logic       brk;
        logic       start_seen;
        logic       false_start;
        logic       sample;
    } rx_event_t;

    // Transmit side events from the transmit shifter.
    typedef struct packed {
        logic load_req;
        logic queued;
        logic busy;
    } tx_event_t;

endpackage

// *** core/sci_idle_detect.sv ***
// Idle line detector: counts consecutive ones on the receive input at bit ticks.
// Assumes the input is already synchronised and bit_tick is a one-cycle pulse per bit time.
module sci_idle_detect (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       bit_tick,
    input  wire logic       rx_level,
    input  wire logic       nine_bit,
    input  wire logic       armed,
    output logic            idle_hit
);

    typedef struct packed {
        logic [3:0] ones;
        logic       hit;
    } idle_state_t;

    idle_state_t state;
    idle_state_t next_state;

    // The detector fires once per run of ones, so a long idle line raises a single event.
    always_comb begin
        next_state     = state;
        next_state.hit = 1'b0;
        if (bit_tick) begin
            if (!rx_level) begin
                next_state.ones = 4'h0;
            end else if (state.ones != 4'hF) begin
                next_state.ones = state.ones + 4'h1;
                if (armed && state.ones == (nine_bit ? sci_flags_pkg::IDLE_LONG : sci_flags_pkg::IDLE_SHORT)) begin
                    next_state.hit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign idle_hit = state.hit;

endmodule

// *** tb/sci_status_error_flags_assertions.sv ***
// Checker for the serial status block: bus timing, transmit handoff and interrupt causes.
// Sees only the top ports; a shadow of the control writes stands in for the hidden state.
module sci_flags_checker (
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic [7:0]               paddr,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [31:0]              pwdata,
    input wire logic                     pready,
    input wire logic                     rx_pin,
    input wire sci_flags_pkg::rx_event_t rx_ev,
    input wire sci_flags_pkg::tx_event_t tx_ev,
    input wire logic [8:0]               tx_load_data,
    input wire logic                     tx_load,
    input wire logic                     tx_irq,
    input wire logic                     rx_irq,
    input wire logic                     err_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [7:0] aux;
    logic [7:0] ctl;
    logic       take;
    logic       rx_on;
    logic       brk_ok;
    // A break only counts once the line has gone high again since the last one.
    always_ff @(posedge clock) begin
        if (rst || rx_pin) begin
            brk_ok <= 1'b1;
        end else if (rx_ev.brk) begin
            brk_ok <= 1'b0;
        end
    end
    assign take = psel && penable && !pready && pwrite;
    assign rx_on = aux[sci_flags_pkg::AX_EN] && aux[sci_flags_pkg::AX_RXEN];
    // Shadows change at the edge that takes a write, as the registers do; ninth bits survive reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            aux <= sci_flags_pkg::AUX_RESET;
            ctl[3:0] <= 4'h0;
        end else if (take && paddr == sci_flags_pkg::ADDR_CTRL_AUX) begin
            aux <= pwdata[7:0];
        end else if (take && paddr == sci_flags_pkg::ADDR_CTRL3) begin
            ctl <= pwdata[7:0];
        end
    end
    chk_bus_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no bus answer");
    chk_load_cause: assert property (tx_load |-> $past(tx_ev.load_req))
        else $error("unrequested handoff");
    chk_ninth_load: assert property (tx_load && aux[sci_flags_pkg::AX_NINE]
        |-> tx_load_data[8] == ctl[sci_flags_pkg::C3_TX9]) else $error("wrong ninth bit");
    chk_empty_irq: assert property (tx_load && aux[0] && aux[sci_flags_pkg::AX_TXEIE] |-> ##[1:2] tx_irq)
        else $error("no transmit request");
    chk_off_quiet: assert property (!aux[0] && !$past(aux[0]) |-> !tx_irq)
        else $error("transmit request while off");
    chk_full_irq: assert property (rx_ev.done && rx_on && aux[sci_flags_pkg::AX_RXFIE] |-> ##[1:2] rx_irq)
        else $error("no receive request");
    chk_break_err: assert property (rx_ev.brk && brk_ok && rx_on && ctl[1] |-> ##[1:2] err_irq)
        else $error("no error request on break");
    chk_error_irq: assert property (rx_ev.done && rx_on && (rx_ev.noise && ctl[2]
        || rx_ev.frame_err && ctl[1] || rx_ev.parity_err && ctl[0]) |-> ##[1:2] err_irq)
        else $error("no error request");
endmodule

bind sci_status_error_flags sci_flags_checker sci_flags_checker_inst (.clock, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pready, .rx_pin, .rx_ev, .tx_ev, .tx_load_data, .tx_load, .tx_irq, .rx_irq, .err_irq);

// *** tb/sci_far_side.sv ***
// Far-side shifter model: free bit ticks, a transmit shifter and a scripted receiver.
// Driven by the bench through its tasks; the receive line rests high between frames unless a break is held.
module sci_far_side #(
    parameter int BIT = 8
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                tx_load,
    output sci_flags_pkg::rx_event_t rx_ev,
    output sci_flags_pkg::tx_event_t tx_ev,
    output logic                     rx_pin,
    output logic                     bit_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int tick = 0;
    int busy = 0;
    initial begin
        rx_ev = '0;
        tx_ev = '0;
        rx_pin = 1'b1;
        bit_tick = 1'b0;
    end
    // The shifter stays busy for ten bit times, so completion waits for the line.
    always @(posedge clock) begin
        tick <= (tick + 1) % BIT;
        bit_tick <= (tick == 0);
        tx_ev.queued <= tx_load;
        busy <= rst ? 0 : tx_load ? 10 * BIT : busy > 0 ? busy - 1 : 0;
        tx_ev.busy <= busy > 0 || tx_load;
        tx_ev.load_req <= busy == 0 && tick == 0 && !tx_load;
    end
    task automatic pulse(input sci_flags_pkg::rx_event_t ev);
        rx_ev <= ev;
        @(posedge clock);
        rx_ev <= '0;
        @(posedge clock);
    endtask
    task automatic send_char(input logic [8:0] d, input logic [2:0] err, input logic nine);
        rx_pin <= 1'b0;
        pulse('{start_seen: 1'b1, default: '0});
        repeat (BIT - 2) @(posedge clock);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            rx_pin <= d[i];
            repeat (BIT) @(posedge clock);
        end
        rx_pin <= !err[1];
        repeat (BIT) @(posedge clock);
        rx_pin <= 1'b1;
        pulse('{done: 1'b1, data: d, noise: err[2], frame_err: err[1], parity_err: err[0], default: '0});
    endtask
    task automatic send_break(input logic hold);
        rx_pin <= 1'b1;
        repeat (2 * BIT) @(posedge clock);
        rx_pin <= 1'b0;
        repeat (11 * BIT) @(posedge clock);
        pulse('{brk: 1'b1, default: '0});
        rx_pin <= !hold;
    endtask
endmodule

// *** tb/testbench.sv ***
// Bench for the serial status block: register reads, flag clearing and transmit handoff.
// Assumes the far-side model makes the receive events; a watcher checks every read answer and each handoff.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, rx_pin, bit_tick;
    logic        tx_load, tx_irq, rx_irq, err_irq;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata;
    logic [8:0]  tx_load_data, t, tx_q[$];
    logic [32:0] exp_q[$], msk_q[$], e, m;
    localparam logic [7:0] CT3 = sci_flags_pkg::ADDR_CTRL3;
    localparam logic [7:0] ST1 = sci_flags_pkg::ADDR_STATUS1;
    localparam logic [7:0] ST2 = sci_flags_pkg::ADDR_STATUS2;
    localparam logic [7:0] DAT = sci_flags_pkg::ADDR_DATA;
    int          miscompares = 0;
    int          checked = 0;
    sci_flags_pkg::rx_event_t rx_ev;
    sci_flags_pkg::tx_event_t tx_ev;
    sci_status_error_flags sci_status_error_flags_inst (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .rx_pin, .bit_tick, .rx_ev, .tx_ev, .tx_load_data, .tx_load, .tx_irq,
        .rx_irq, .err_irq);
    sci_far_side sci_far_side_inst (.clock, .rst, .tx_load, .rx_ev, .tx_ev, .rx_pin, .bit_tick);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic wrap_up;
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x, k);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            exp_q.push_back(x);
            msk_q.push_back(k);
        end
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k);
        apb(1'b0, a, 32'h0000_0000, {25'h0, x}, {25'h1FF_FFFF, k});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d}, 33'h0, 33'h0);
    endtask
    task automatic setup(input logic nine);
        wr(sci_flags_pkg::ADDR_CTRL_AUX, {3'h3, 2'h3, nine, 2'h3});
        wr(CT3, 8'h4F);
    endtask
    // -----------------------------------------------------------------
    // Watcher: each read answer is checked against the oldest note
    // -----------------------------------------------------------------
    always @(posedge clock) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            checked++;
            if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
                miscompares++;
                $display("MISMATCH read %h expected %h seen %h", paddr, e, {pslverr, prdata});
            end
        end
        if (tx_load === 1'b1) begin
            t = tx_q.pop_front();
            checked++;
            if (tx_load_data !== t) begin
                miscompares++;
                $display("MISMATCH tx_load_data expected %h seen %h", t, tx_load_data);
            end
        end
    end
    // The run needs under two thousand cycles; the limit leaves ample margin.
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        wrap_up;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rst} = {11'h000, 32'h0000_0000, 1'b1};
        void'($urandom(32'h0000_8BDD));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(ST1, 8'hC0, 8'hFF);
        rd(ST2, 8'h00, 8'h03);
        rd(CT3, 8'h00, 8'h0F);
        apb(1'b0, 8'h14, 32'h0000_0000, {1'b1, 32'h0}, {1'b1, 32'hFFFF_FFFF});
        setup(1'b1);
        rd(CT3, 8'h4F, 8'h4F);
        b = 8'($urandom);
        tx_q.push_back({1'b1, b});
        rd(ST1, 8'hC0, 8'hFF);
        wr(DAT, b);
        while (tx_load !== 1'b1) @(posedge clock);
        rd(ST1, 8'h80, 8'hFF);
        repeat (100) @(posedge clock);
        rd(ST1, 8'hC0, 8'hFF);
        b = 8'($urandom);
        sci_far_side_inst.send_char({1'b1, b}, 3'h0, 1'b1);
        rd(ST1, 8'hE0, 8'hFF);
        rd(DAT, b, 8'hFF);
        rd(CT3, 8'h80, 8'h80);
        rd(ST1, 8'hC0, 8'hFF);
        repeat (120) @(posedge clock);
        rd(ST1, 8'hD0, 8'hFF);
        rd(DAT, b, 8'hFF);
        rd(ST1, 8'hC0, 8'hFF);
        repeat (120) @(posedge clock);
        rd(ST1, 8'hC0, 8'hFF);
        sci_far_side_inst.send_char({1'b0, b}, 3'h0, 1'b1);
        rd(ST1, 8'hE0, 8'hFF);
        sci_far_side_inst.send_char({1'b0, ~b}, 3'h0, 1'b1);
        rd(DAT, b, 8'hFF);
        rd(ST1, 8'hC8, 8'hFF);
        rd(DAT, b, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            sci_far_side_inst.send_char({1'b0, b}, 3'h4 >> k, 1'b1);
            rd(ST1, 8'hE0 | (8'h04 >> k), 8'hFF);
            rd(DAT, b, 8'hFF);
        end
        sci_far_side_inst.pulse('{start_seen: 1'b1, default: '0});
        rd(ST2, 8'h01, 8'h01);
        sci_far_side_inst.pulse('{false_start: 1'b1, default: '0});
        rd(ST2, 8'h00, 8'h01);
        setup(1'b0);
        sci_far_side_inst.send_char({1'b0, b | 8'h80}, 3'h0, 1'b0);
        rd(CT3, 8'h80, 8'h80);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(CT3, 8'hC0, 8'hCF);
        setup(1'b1);
        sci_far_side_inst.send_break(1'b1);
        rd(ST1, 8'hE2, 8'hFF);
        rd(CT3, 8'h00, 8'h80);
        rd(ST2, 8'h02, 8'h02);
        rd(DAT, 8'h00, 8'h00);
        rd(ST2, 8'h00, 8'h02);
        sci_far_side_inst.pulse('{brk: 1'b1, default: '0});
        rd(ST2, 8'h00, 8'h02);
        sci_far_side_inst.send_break(1'b0);
        rd(ST2, 8'h02, 8'h02);
        wrap_up;
    end
endmodule
